// ---- dlct_top.sv ----
// Dual counter/timer with AXI4-Lite register access
//
// Operation
// - Each timer holds a 16-bit count, read and written as low and high bytes.
// - Each timer has its own two mode bits selecting one of four modes.
// - Mode 0 counts 13 bits: high byte plus low-byte bits 4 to 0.
// - 13-bit wrap to zero sets the overflow flag and may request an interrupt.
// - Counter select one counts falling edges of the timer's count pin.
// - Counter select zero counts system clock or the prescaled clock.
// - Count only while run is set and gate is off or gate input active.
// - Setting run keeps the present count; counting resumes from it.
// - Timer one mirrors timer zero using the second gate input and polarity.
// - Mode 1 is mode 0 extended to all sixteen bits.
// - Mode 2 counts low byte, reloads it from high byte, sets flag on wrap.
// - Mode 3 low byte is an 8-bit counter with timer zero's controls.
// - Mode 3 high byte counts clocks, runs on timer one run, sets its flag.
// - In mode 3 timer one runs without pins or flag, still giving overflow.
// - Timer one in mode 3 stops; under split, its mode governs running.
// - Each overflow interrupt is forwarded only with its enable bit set.
// - Prescaler gives clock divided by 12, 4, 48, or external clock by 8.
// - Hardware sets flags; software or interrupt vectoring clears them.
`timescale 1ns/1ns
`default_nettype none
module dlct_top
  import dlct_pkg::*;
(
  input  wire logic        I_CLK,                  // System clock, 25 MHz
  input  wire logic        I_RESET,                // Synchronous reset, high
  input  wire logic [7:0]  I_AWADDR,               // Write address
  input  wire logic        I_AWVALID,              // Write address valid
  output logic             O_AWREADY,              // Write address ready
  input  wire logic [31:0] I_WDATA,                // Write data
  input  wire logic [3:0]  I_WSTRB,                // Write byte strobes
  input  wire logic        I_WVALID,               // Write data valid
  output logic             O_WREADY,               // Write data ready
  output logic [1:0]       O_BRESP,                // Write response
  output logic             O_BVALID,               // Write response valid
  input  wire logic        I_BREADY,               // Write response ready
  input  wire logic [7:0]  I_ARADDR,               // Read address
  input  wire logic        I_ARVALID,              // Read address valid
  output logic             O_ARREADY,              // Read address ready
  output logic [31:0]      O_RDATA,                // Read data
  output logic [1:0]       O_RRESP,                // Read response
  output logic             O_RVALID,               // Read data valid
  input  wire logic        I_RREADY,               // Read data ready
  input  wire logic        I_TIMER_ZERO_COUNT_PIN, // Timer zero count pin
  input  wire logic        I_TIMER_ONE_COUNT_PIN,  // Timer one count pin
  input  wire logic        I_EXT_IRQ_INPUT_ZERO,   // Gate input for timer zero
  input  wire logic        I_EXT_IRQ_INPUT_ONE,    // Gate input for timer one
  input  wire logic        I_EXT_CLK,              // External prescaler clock
  input  wire logic        I_ZERO_VECTOR_ACK,      // Pulse: zero service entered
  input  wire logic        I_ONE_VECTOR_ACK,       // Pulse: one service entered
  output logic             O_ZERO_IRQ,             // Timer zero interrupt
  output logic             O_ONE_IRQ,              // Timer one interrupt
  output logic             O_ONE_OVERFLOW          // Timer one overflow pulse
);

  typedef struct packed {
    logic       ovf_zero;
    logic       run_zero;
    logic       ovf_one;
    logic       run_one;
    logic [7:0] mode_reg;
    logic [7:0] clk_reg;
    logic [7:0] lo_zero;
    logic [7:0] hi_zero;
    logic [7:0] lo_one;
    logic [7:0] hi_one;
    logic [7:0] irq_en_reg;
    logic [7:0] ext_cfg_reg;
    logic       one_pulse;
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } dlct_state_t;

  dlct_state_t r;
  dlct_state_t next_r;

  logic cnt_zero_fall, cnt_one_fall;
  logic gate_zero_lvl, gate_one_lvl, ext_clk_rise;
  logic pre_tick;

  // Every pin passes two flops before the counters see it
  dlct_sync u_sync_cnt_zero (
    .I_CLK  (I_CLK),
    .I_RESET(I_RESET),
    .i_pin  (I_TIMER_ZERO_COUNT_PIN),
    .o_level(),
    .o_fall (cnt_zero_fall),
    .o_rise ()
  );
  dlct_sync u_sync_cnt_one (
    .I_CLK  (I_CLK),
    .I_RESET(I_RESET),
    .i_pin  (I_TIMER_ONE_COUNT_PIN),
    .o_level(),
    .o_fall (cnt_one_fall),
    .o_rise ()
  );
  dlct_sync u_sync_gate_zero (
    .I_CLK  (I_CLK),
    .I_RESET(I_RESET),
    .i_pin  (I_EXT_IRQ_INPUT_ZERO),
    .o_level(gate_zero_lvl),
    .o_fall (),
    .o_rise ()
  );
  dlct_sync u_sync_gate_one (
    .I_CLK  (I_CLK),
    .I_RESET(I_RESET),
    .i_pin  (I_EXT_IRQ_INPUT_ONE),
    .o_level(gate_one_lvl),
    .o_fall (),
    .o_rise ()
  );
  dlct_sync u_sync_ext_clk (
    .I_CLK  (I_CLK),
    .I_RESET(I_RESET),
    .i_pin  (I_EXT_CLK),
    .o_level(),
    .o_fall (),
    .o_rise (ext_clk_rise)
  );

  dlct_prescaler u_pre (
    .I_CLK     (I_CLK),
    .I_RESET   (I_RESET),
    .i_select  (r.clk_reg[CKS_PRE +: 2]),
    .i_ext_rise(ext_clk_rise),
    .o_tick    (pre_tick)
  );

  // One counting step: returns {wrap, high, low}
  function automatic logic [16:0] count_step(input dlct_mode_t mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  v8;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    v16 = {1'b0, hi, lo} + 17'h00001;
    v8  = {1'b0, lo} + 9'h001;
    case (mode)
      MODE_13BIT:  count_step = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      MODE_16BIT:  count_step = v16;
      MODE_RELOAD: count_step = {v8[8], hi, (v8[8] ? hi : v8[7:0])};
      default:     count_step = {v8[8], hi, v8[7:0]};
    endcase
  endfunction

  dlct_mode_t mode_zero, mode_one;
  logic       split, tick_zero, tick_one, tick_hi_split;
  logic       en_zero, en_one, act_zero, act_one;
  logic [16:0] step_zero, step_one;
  logic [8:0]  step_hi;
  logic        set_zero, set_one;
  logic        wr_go, wr_hit;
  logic [7:0]  rd_val;
  logic        rd_hit;

  // Timing sources, gating and counting steps for both timers
  always_comb begin
    mode_zero = dlct_mode_t'(r.mode_reg[MOD_SEL_ZERO +: 2]);
    mode_one  = dlct_mode_t'(r.mode_reg[MOD_SEL_ONE +: 2]);
    split     = (mode_zero == MODE_SPLIT);
    tick_zero = r.mode_reg[MOD_CNT_ZERO] ? cnt_zero_fall
              : (r.clk_reg[CKS_SYS_ZERO] ? 1'b1 : pre_tick);
    // Timer one loses its pin while timer zero is split
    tick_one  = (r.mode_reg[MOD_CNT_ONE] && !split) ? cnt_one_fall
              : (r.clk_reg[CKS_SYS_ONE] ? 1'b1 : pre_tick);
    tick_hi_split = r.clk_reg[CKS_SYS_ZERO] ? 1'b1 : pre_tick;
    act_zero  = (gate_zero_lvl == r.ext_cfg_reg[POL_ZERO]);
    act_one   = (gate_one_lvl == r.ext_cfg_reg[POL_ONE]);
    en_zero   = r.run_zero && (!r.mode_reg[MOD_GATE_ZERO] || act_zero);
    en_one    = split ? (mode_one != MODE_SPLIT)
              : (r.run_one && (!r.mode_reg[MOD_GATE_ONE] || act_one)
                 && (mode_one != MODE_SPLIT));
    step_zero = count_step(mode_zero, r.lo_zero, r.hi_zero);
    step_one  = count_step(mode_one, r.lo_one, r.hi_one);
    step_hi   = {1'b0, r.hi_zero} + 9'h001;
  end

  // Bus decode helpers
  assign wr_go  = r.aw_held && r.w_held && !r.bvalid;
  assign wr_hit = (r.aw_addr == OFS_CONTROL) || (r.aw_addr == OFS_MODE)
               || (r.aw_addr == OFS_CLKSEL)  || (r.aw_addr == OFS_ZERO_LO)
               || (r.aw_addr == OFS_ZERO_HI) || (r.aw_addr == OFS_ONE_LO)
               || (r.aw_addr == OFS_ONE_HI)  || (r.aw_addr == OFS_IRQ_EN)
               || (r.aw_addr == OFS_EXT_CFG);

  // Read mux; the indeterminate mode-0 bits simply read what is stored
  always_comb begin
    rd_hit = 1'b1;
    case ({I_ARADDR[7:2], 2'b00})
      OFS_CONTROL: rd_val = {r.ovf_one, r.run_one, r.ovf_zero, r.run_zero, 4'h0};
      OFS_MODE:    rd_val = r.mode_reg;
      OFS_CLKSEL:  rd_val = r.clk_reg;
      OFS_ZERO_LO: rd_val = r.lo_zero;
      OFS_ZERO_HI: rd_val = r.hi_zero;
      OFS_ONE_LO:  rd_val = r.lo_one;
      OFS_ONE_HI:  rd_val = r.hi_one;
      OFS_IRQ_EN:  rd_val = r.irq_en_reg;
      OFS_EXT_CFG: rd_val = r.ext_cfg_reg;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Next state: counting first, then software writes, then flag sets on top
  always_comb begin
    next_r           = r;
    next_r.one_pulse = 1'b0;
    set_zero         = 1'b0;
    set_one          = 1'b0;

    // Timer zero; run never touches the count itself
    if (en_zero && tick_zero) begin
      next_r.lo_zero = step_zero[7:0];
      if (!split) begin
        next_r.hi_zero = step_zero[15:8];
      end
      set_zero = step_zero[16];
    end
    // Split high byte runs from timer one's run bit and owns its flag
    if (split && r.run_one && tick_hi_split) begin
      next_r.hi_zero = step_hi[7:0];
      set_one        = step_hi[8];
    end
    // Timer one; its wrap still leaves the block while zero is split
    if (en_one && tick_one) begin
      next_r.lo_one    = step_one[7:0];
      next_r.hi_one    = step_one[15:8];
      next_r.one_pulse = step_one[16];
      if (!split) begin
        set_one = set_one | step_one[16];
      end
    end

    // Write address and data are taken in either order
    if (I_AWVALID && O_AWREADY) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = {I_AWADDR[7:2], 2'b00};
    end
    if (I_WVALID && O_WREADY) begin
      next_r.w_held  = 1'b1;
      next_r.w_data  = I_WDATA[7:0];
      next_r.w_lane0 = I_WSTRB[0];
    end

    // Vectoring clears the flag
    if (I_ZERO_VECTOR_ACK) begin
      next_r.ovf_zero = 1'b0;
    end
    if (I_ONE_VECTOR_ACK) begin
      next_r.ovf_one = 1'b0;
    end

    // Register write; a byte write wins over a count in the same cycle
    if (wr_go) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (r.w_lane0) begin
        case (r.aw_addr)
          OFS_CONTROL: begin
            next_r.ovf_one  = r.w_data[CTL_OVF_ONE];
            next_r.run_one  = r.w_data[CTL_RUN_ONE];
            next_r.ovf_zero = r.w_data[CTL_OVF_ZERO];
            next_r.run_zero = r.w_data[CTL_RUN_ZERO];
          end
          OFS_MODE:    next_r.mode_reg    = r.w_data;
          OFS_CLKSEL:  next_r.clk_reg     = {4'h0, r.w_data[3:0]};
          OFS_ZERO_LO: next_r.lo_zero     = r.w_data;
          OFS_ZERO_HI: next_r.hi_zero     = r.w_data;
          OFS_ONE_LO:  next_r.lo_one      = r.w_data;
          OFS_ONE_HI:  next_r.hi_one      = r.w_data;
          OFS_IRQ_EN:  next_r.irq_en_reg  = r.w_data;
          OFS_EXT_CFG: next_r.ext_cfg_reg = r.w_data;
          default:     next_r.bresp       = RESP_SLVERR;
        endcase
      end
    end
    if (r.bvalid && I_BREADY) begin
      next_r.bvalid = 1'b0;
    end

    // Hardware set beats any clear arriving in the same cycle
    if (set_zero) begin
      next_r.ovf_zero = 1'b1;
    end
    if (set_one) begin
      next_r.ovf_one = 1'b1;
    end

    // Read channel: one read in flight, answered the cycle after the address
    if (I_ARVALID && O_ARREADY) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_val;
      next_r.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid && I_RREADY) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Handshake outputs
  assign O_AWREADY = !r.aw_held && !r.bvalid;
  assign O_WREADY  = !r.w_held && !r.bvalid;
  assign O_ARREADY = !r.rvalid;
  assign O_BVALID  = r.bvalid;
  assign O_BRESP   = r.bresp;
  assign O_RVALID  = r.rvalid;
  assign O_RRESP   = r.rresp;
  assign O_RDATA   = {24'h000000, r.rdata};

  // Interrupt requests follow flag and enable
  assign O_ZERO_IRQ     = r.ovf_zero && r.irq_en_reg[IEN_ZERO];
  assign O_ONE_IRQ      = r.ovf_one && r.irq_en_reg[IEN_ONE];
  assign O_ONE_OVERFLOW = r.one_pulse;

endmodule
`default_nettype wire

// ---- dlct_pkg.sv ----
// Shared constants for the dual counter/timer block: map, fields, modes, divisors
package dlct_pkg;

  // Register bus widths
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  // Register byte offsets
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_MODE    = 8'h04;
  localparam logic [7:0]  OFS_CLKSEL  = 8'h08;
  localparam logic [7:0]  OFS_ZERO_LO = 8'h0c;
  localparam logic [7:0]  OFS_ZERO_HI = 8'h10;
  localparam logic [7:0]  OFS_ONE_LO  = 8'h14;
  localparam logic [7:0]  OFS_ONE_HI  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_EN  = 8'h1c;
  localparam logic [7:0]  OFS_EXT_CFG = 8'h20;

  // timer_control_reg fields (bits 3:0 read zero)
  localparam int          CTL_OVF_ONE  = 7;
  localparam int          CTL_RUN_ONE  = 6;
  localparam int          CTL_OVF_ZERO = 5;
  localparam int          CTL_RUN_ZERO = 4;

  // timer_mode_reg fields
  localparam int          MOD_GATE_ONE  = 7;
  localparam int          MOD_CNT_ONE   = 6;
  localparam int          MOD_SEL_ONE   = 4;
  localparam int          MOD_GATE_ZERO = 3;
  localparam int          MOD_CNT_ZERO  = 2;
  localparam int          MOD_SEL_ZERO  = 0;

  // timer_clock_select_reg fields
  localparam int          CKS_SYS_ONE  = 3;
  localparam int          CKS_SYS_ZERO = 2;
  localparam int          CKS_PRE      = 0;

  // interrupt_enable_reg and ext_irq_config_reg fields
  localparam int          IEN_ZERO     = 1;
  localparam int          IEN_ONE      = 3;
  localparam int          POL_ZERO     = 3;
  localparam int          POL_ONE      = 7;

  // Reset value of every register
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Prescaler divisors
  localparam int          DIV_FOUR     = 4;
  localparam int          DIV_TWELVE   = 12;
  localparam int          DIV_FORTY8   = 48;
  localparam int          DIV_EXT      = 8;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } dlct_mode_t;

  // Prescale codes
  typedef enum logic [1:0] {
    PRE_DIV12 = 2'b00,
    PRE_DIV4  = 2'b01,
    PRE_DIV48 = 2'b10,
    PRE_EXT8  = 2'b11
  } dlct_pre_t;

endpackage

// ---- dlct_sync.sv ----
// Two-flop synchroniser with edge detection for one asynchronous pin
`timescale 1ns/1ns
`default_nettype none
module dlct_sync
  import dlct_pkg::*;
(
  input  wire logic I_CLK,    // System clock
  input  wire logic I_RESET,  // Synchronous reset, active high
  input  wire logic i_pin,    // Asynchronous pin
  output logic      o_level,  // Synchronised level
  output logic      o_fall,   // One-cycle pulse on a falling edge
  output logic      o_rise    // One-cycle pulse on a rising edge
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } dlct_sync_t;

  dlct_sync_t r;
  dlct_sync_t next_r;

  // Shift chain; only the second and third stages feed logic
  always_comb begin
    next_r      = r;
    next_r.meta = i_pin;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.sync;
  assign o_fall  = r.prev & ~r.sync;
  assign o_rise  = ~r.prev & r.sync;

endmodule
`default_nettype wire

// ---- dlct_prescaler.sv ----
// Shared clock prescaler producing a one-cycle count tick
`timescale 1ns/1ns
`default_nettype none
module dlct_prescaler
  import dlct_pkg::*;
(
  input  wire logic       I_CLK,     // System clock
  input  wire logic       I_RESET,   // Synchronous reset, active high
  input  wire logic [1:0] i_select,  // Prescale code
  input  wire logic       i_ext_rise,// Synchronised external clock edge
  output logic            o_tick     // One-cycle prescaled tick
);

  typedef struct packed {
    logic [5:0] cnt48;
    logic [3:0] cnt12;
    logic [2:0] cnt8;
    logic       tick;
  } dlct_pre_state_t;

  dlct_pre_state_t r;
  dlct_pre_state_t next_r;

  // Free-running dividers; the selected one's terminal count becomes the tick
  always_comb begin
    next_r       = r;
    next_r.cnt48 = (r.cnt48 == 6'(DIV_FORTY8 - 1)) ? 6'h00 : r.cnt48 + 6'h01;
    next_r.cnt12 = (r.cnt12 == 4'(DIV_TWELVE - 1)) ? 4'h0 : r.cnt12 + 4'h1;
    if (i_ext_rise) begin
      next_r.cnt8 = r.cnt8 + 3'h1;
    end
    case (dlct_pre_t'(i_select))
      PRE_DIV12: next_r.tick = (r.cnt12 == 4'(DIV_TWELVE - 1));
      PRE_DIV4:  next_r.tick = (r.cnt48[1:0] == 2'(DIV_FOUR - 1));
      PRE_DIV48: next_r.tick = (r.cnt48 == 6'(DIV_FORTY8 - 1));
      PRE_EXT8:  next_r.tick = i_ext_rise && (r.cnt8 == 3'(DIV_EXT - 1));
      default:   next_r.tick = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_tick = r.tick;

endmodule
`default_nettype wire

// ---- dlct_chk.sv ----
// Checker: bus handshakes, read responses and reset state of the timer block
`timescale 1ns/1ns
`default_nettype none
module dlct_chk
  import dlct_pkg::*;
(
  input wire logic        I_CLK,      // Clock
  input wire logic        I_RESET,    // Reset
  input wire logic        I_AWVALID,  // AW valid
  input wire logic        O_AWREADY,  // AW ready
  input wire logic        I_WVALID,   // W valid
  input wire logic        O_WREADY,   // W ready
  input wire logic [1:0]  O_BRESP,    // B resp
  input wire logic        O_BVALID,   // B valid
  input wire logic        I_BREADY,   // B ready
  input wire logic [7:0]  I_ARADDR,   // AR addr
  input wire logic        I_ARVALID,  // AR valid
  input wire logic        O_ARREADY,  // AR ready
  input wire logic [31:0] O_RDATA,    // R data
  input wire logic [1:0]  O_RRESP,    // R resp
  input wire logic        O_RVALID,   // R valid
  input wire logic        I_RREADY,   // R ready
  input wire logic        O_ZERO_IRQ, // IRQ zero
  input wire logic        O_ONE_IRQ   // IRQ one
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  // Transfer steps shared by the properties
  sequence both_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence read_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  write_answer_a: assert property (both_taken |=> !O_BVALID ##1 O_BVALID)
    else $error("write response not two edges after transfer");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped early");
  read_answer_a: assert property (read_taken |=> O_RVALID)
    else $error("read answer late");
  write_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write accepted while response pending");
  read_block_a: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read accepted while data pending");
  unmapped_err_a: assert property (read_taken ##0 (I_ARADDR > 8'h23)
    |=> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0) else $error("unmapped read not refused");
  mapped_ok_a: assert property (read_taken ##0 (I_ARADDR <= 8'h23)
    |=> O_RRESP == RESP_OKAY && O_RDATA[31:8] == 24'h0) else $error("mapped read bad");
  reset_state_a: assert property ($fell(I_RESET) |-> O_AWREADY && O_WREADY && O_ARREADY
    && !O_BVALID && !O_RVALID && !O_ZERO_IRQ && !O_ONE_IRQ) else $error("bad reset state");
endmodule
bind dlct_top dlct_chk dlct_chk_i (.I_CLK, .I_RESET, .I_AWVALID, .O_AWREADY, .I_WVALID,
  .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
  .O_RRESP, .O_RVALID, .I_RREADY, .O_ZERO_IRQ, .O_ONE_IRQ);
`default_nettype wire

// ---- dlct_pin_model.sv ----
// Far-side model: count pins, gate inputs and the external prescale clock
`timescale 1ns/1ns
`default_nettype none
module dlct_pin_model (
  input  wire logic i_clk,       // System clock
  output logic      o_pin_zero,  // Count pin, timer zero
  output logic      o_pin_one,   // Count pin, timer one
  output logic      o_gate_zero, // Gate input zero
  output logic      o_gate_one,  // Gate input one
  output logic      o_ext_clk    // Prescale clock, free running
);
  // Pins idle high so each pulse gives exactly one falling edge
  initial begin
    o_pin_zero = 1'b1;
    o_pin_one = 1'b1;
    o_gate_zero = 1'b0;
    o_gate_one = 1'b0;
    o_ext_clk = 1'b0;
  end
  // External prescale clock, six system clocks a period
  always begin
    repeat (3) @(posedge i_clk);
    o_ext_clk <= ~o_ext_clk;
  end
  // Low phase lasts four clocks and high phase at least five, so the synchroniser never misses one
  task automatic falls(input bit one, input int n);
    repeat (n) begin
      @(posedge i_clk);
      if (one) o_pin_one <= 1'b0;
      else o_pin_zero <= 1'b0;
      repeat (4) @(posedge i_clk);
      if (one) o_pin_one <= 1'b1;
      else o_pin_zero <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
  endtask
  // Gate level changes just after a clock edge
  task automatic set_gate(input bit one, input logic lvl);
    @(posedge i_clk);
    if (one) o_gate_one <= lvl;
    else o_gate_zero <= lvl;
  endtask
endmodule
`default_nettype wire

// ---- test_dual_legacy_counter_timer.sv ----
// Self-checking bench for the dual counter/timer block
`timescale 1ns/1ns
`default_nettype none
module test_dual_legacy_counter_timer;
  import dlct_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, ack0 = 1'b0, ack1 = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq0, irq1, ovf1;
  logic        pin0, pin1, timer_zero_gate_enable, gate1, eclk;
  logic [1:0]  bresp, rresp, r;
  int          fail_count = 0, checks = 0, cyc = 0, one_wraps = 0;

  dlct_top dlct_top_i (.I_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_TIMER_ZERO_COUNT_PIN(pin0),
    .I_TIMER_ONE_COUNT_PIN(pin1), .I_EXT_IRQ_INPUT_ZERO(timer_zero_gate_enable), .I_EXT_IRQ_INPUT_ONE(gate1),
    .I_EXT_CLK(eclk), .I_ZERO_VECTOR_ACK(ack0), .I_ONE_VECTOR_ACK(ack1),
    .O_ZERO_IRQ(irq0), .O_ONE_IRQ(irq1), .O_ONE_OVERFLOW(ovf1));
  dlct_pin_model pin_i (.i_clk(clk), .o_pin_zero(pin0), .o_pin_one(pin1),
    .o_gate_zero(timer_zero_gate_enable), .o_gate_one(gate1), .o_ext_clk(eclk));

  // 25 MHz clock
  always #20 clk = ~clk;
  // Whole run needs about 1600 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (ovf1 === 1'b1) begin
      one_wraps++;
    end
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] timeout expected done got hang");
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string s, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h got %h", s, e, g);
    end
  endtask
  task automatic cmpr(input string s, input int lo, input int hi, input logic [7:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d got %h", s, lo, hi, g);
    end
  endtask
  // Both write channels offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    d = rdata[7:0];
    r = rresp;
  endtask
  // Masked register read; top bits of a 13-bit low byte are ignored
  task automatic rc(input string s, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    rd(a);
    cmp(s, {RESP_OKAY, e}, {r, d & m});
  endtask

  task automatic s_reset();
    for (int a = 0; a <= 32; a += 4) rc("reset value", 8'(a), 8'hff, REG_RESET);
    rd(8'h40);
    cmp("unmapped read", {RESP_SLVERR, 8'h00}, {r, d});
  endtask
  task automatic s_mode0();
    wr(OFS_IRQ_EN, 8'h0a);
    wr(OFS_MODE, 8'h04);
    wr(OFS_ZERO_LO, 8'h1e);
    wr(OFS_ZERO_HI, 8'hff);
    wr(OFS_CONTROL, 8'h10);
    pin_i.falls(0, 3);
    rc("13-bit low", OFS_ZERO_LO, 8'h1f, 8'h01);
    rc("13-bit high", OFS_ZERO_HI, 8'hff, 8'h00);
    rc("zero flag", OFS_CONTROL, 8'h20, 8'h20);
    cmp("zero irq", 10'h001, {9'h000, irq0});
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    @(posedge clk);
    cmp("zero irq after ack", 10'h000, {9'h000, irq0});
  endtask
  task automatic s_mode2();
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_MODE, 8'h06);
    wr(OFS_ZERO_LO, 8'hfe);
    wr(OFS_ZERO_HI, 8'h80);
    wr(OFS_CONTROL, 8'h10);
    pin_i.falls(0, 3);
    rc("reload low", OFS_ZERO_LO, 8'hff, 8'h81);
    rc("reload high", OFS_ZERO_HI, 8'hff, 8'h80);
    rc("reload flag", OFS_CONTROL, 8'h20, 8'h20);
    wr(OFS_CONTROL, 8'h00);
    rc("flag cleared", OFS_CONTROL, 8'hff, 8'h00);
  endtask
  task automatic s_gate();
    wr(OFS_EXT_CFG, 8'h80);
    wr(OFS_MODE, 8'hd0);
    wr(OFS_CONTROL, 8'h40);
    pin_i.falls(1, 2);
    rc("gate closed", OFS_ONE_LO, 8'hff, 8'h00);
    pin_i.set_gate(1, 1'b1);
    repeat (4) @(posedge clk);
    pin_i.falls(1, 2);
    rc("gate open", OFS_ONE_LO, 8'hff, 8'h02);
    wr(OFS_CONTROL, 8'h00);
    pin_i.falls(1, 1);
    wr(OFS_CONTROL, 8'h40);
    pin_i.falls(1, 1);
    rc("resumed count", OFS_ONE_LO, 8'hff, 8'h03);
  endtask
  task automatic s_split();
    wr(OFS_MODE, 8'h33);
    wr(OFS_CLKSEL, 8'h0c);
    wr(OFS_ZERO_HI, 8'hf0);
    wr(OFS_CONTROL, 8'h40);
    repeat (30) @(posedge clk);
    rc("split flag", OFS_CONTROL, 8'ha0, 8'h80);
    cmp("one irq", 10'h001, {9'h000, irq1});
    rc("split low idle", OFS_ZERO_LO, 8'hff, 8'h81);
    rc("one stopped", OFS_ONE_LO, 8'hff, 8'h03);
    ack1 <= 1'b1;
    @(posedge clk);
    ack1 <= 1'b0;
    @(posedge clk);
    cmp("one irq after ack", 10'h000, {9'h000, irq1});
    // Timer one still wraps under split, but only the overflow pulse leaves
    wr(OFS_ONE_LO, 8'hf0);
    wr(OFS_MODE, 8'h23);
    repeat (30) @(posedge clk);
    cmp("one overflow", 10'h001, 10'(one_wraps));
    rc("one flag kept", OFS_CONTROL, 8'h80, 8'h00);
    wr(OFS_CONTROL, 8'h00);
  endtask
  task automatic s_prescale();
    logic [7:0] cs [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
    int         ex [5] = '{240 / DIV_TWELVE, 240 / DIV_FOUR, 240 / DIV_FORTY8, 240,
                           240 / (6 * DIV_EXT)};
    wr(OFS_MODE, 8'h01);
    foreach (cs[k]) begin
      wr(OFS_CLKSEL, cs[k]);
      wr(OFS_ZERO_LO, 8'h00);
      wr(OFS_CONTROL, 8'h10);
      repeat (240) @(posedge clk);
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_ZERO_LO);
      cmpr("timed count", ex[k], ex[k] + 4, d);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_mode0();
    s_mode2();
    s_gate();
    s_split();
    s_prescale();
    results();
  end
endmodule
`default_nettype wire
